// file: rsm_pkg.sv
// Purpose: constants for the reset and supply monitor
// Assumes: 32-bit AHB-Lite register window, 10 MHz core_clk
// Notes: byte offsets, field positions and timing counts
package rsm_pkg;
   localparam logic [7:0] OFF_RSTSRC = 8'h00;
   localparam logic [7:0] OFF_PWRCTL = 8'h04;
   localparam logic [7:0] OFF_PWRCTL0 = 8'h08;
   localparam logic [7:0] OFF_AVDCTL = 8'h0c;
   localparam logic [7:0] OFF_OVDCTL = 8'h10;
   localparam logic [7:0] OFF_UVDCTL = 8'h14;
   localparam logic [7:0] OFF_OVDFLT = 8'h18;
   localparam logic [7:0] OFF_UVDFLT = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_BKCTL = 8'h24;
   localparam int FLAG_HI = 31;
   localparam int FLAG_LO = 26;
   localparam int CLR_BIT = 24;
   localparam int EN_BIT = 4;
   localparam int BKRST_BIT = 0;
   // flag index inside the six-bit flag field
   localparam int F_LP = 5;
   localparam int F_WWDG = 4;
   localparam int F_FWDG = 3;
   localparam int F_SW = 2;
   localparam int F_POR = 1;
   localparam int F_EP = 0;
   localparam logic [5:0] FLAGS_RST = 6'h02;
   localparam logic [2:0] LVD_SEL_RST = 3'h0;
   localparam logic [2:0] VSEL_RST = 3'h0;
   localparam logic [1:0] SEL2_RST = 2'h0;
   localparam logic [7:0] FLT_RST = 8'h00;
   localparam int CLK_KHZ = 10000;
   localparam int RST_PULSE_NS = 20000;
   localparam int RST_CYC = (RST_PULSE_NS * CLK_KHZ + 999999) / 1000000;
   localparam int FLT_UNIT = 1024;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] ZERO32 = 32'h00000000;
endpackage : rsm_pkg

// file: rsm_reset_supply.sv
// Purpose: reset scopes, reset pin, reset-source flags and supply detectors
// Assumes: analog comparator outputs and pin are asynchronous to core_clk
// Notes: registers reached over AHB-Lite, zero wait states
// Functional notes
// R1: power reset resets everything except the backup domain
// R2: system reset resets core and peripherals, not debug port or backup
// R3: reset pin driven low during power or system reset until it ends
// R4: sticky read-only flags in bits 31..26: lp, wwdg, fwdg, sw, por, pin
// R5: flags cleared only by power-on or writing bit 24; software clears
// R6: power reset from power-on/down detector or standby return
// R7: backup reset by software bit or backup-domain power-on
// R8: supply below threshold holds power reset active low
// R9: core supply power-up starts a reset sequence on core domain
// R10: low-voltage threshold select in bits 2:0 of power control
// R11: low-voltage detector works only when enabled; flag shows event
// R12: low-voltage event drives event controller line 16
// R13: analog-supply detector has 2-bit select at 1:0, enable, flag
// R14: over-voltage detector enabled when its enable bit is one
// R15: over-voltage threshold select in bits 1:0
// R16: raw over-voltage flag after two-flop synchroniser
// R17: filtered over-voltage flag after 8-bit filter of 1024-clock units
// R18: under-voltage detector enabled when its enable bit is one
// R19: under-voltage threshold select in bits 1:0
// R20: raw under-voltage flag after two-flop synchroniser
// R21: filtered under-voltage flag via 8-bit filter drives interrupt
// R22: regulator output select in bits 2:0 of power control zero
// R23: filter needs full count held; a drop restarts the count
`timescale 1ns/1ps
module rsm_reset_supply #(
   parameter int RST_CYCLES = rsm_pkg::RST_CYC,
   parameter int UNIT_CYCLES = rsm_pkg::FLT_UNIT
) (
   input wire logic core_clk, // 10 MHz clock
   input wire logic external_reset_pin, // sync reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // response
   input wire logic supplyOkN, // main supply below threshold, low
   input wire logic coreSupplyOk, // core supply up
   input wire logic standbyWake, // return from standby
   input wire logic bkpPowerOn, // backup domain power-on
   input wire logic lowPowerReset, // low-power reset request
   input wire logic wwdgReset, // window watchdog reset
   input wire logic fwdgReset, // free watchdog reset
   input wire logic swReset, // software reset request
   input wire logic extResetPinIn, // reset pin level
   output logic extResetPinOut, // reset pin drive value
   output logic extResetPinOe, // reset pin drive enable
   output logic powerResetN, // power reset, low
   output logic systemResetN, // system reset, low
   output logic backupResetN, // backup reset, low
   input wire logic lvdCmp, // low-voltage comparator
   input wire logic avdCmp, // analog-supply comparator
   input wire logic ovdCmp, // core over-voltage comparator
   input wire logic uvdCmp, // core under-voltage comparator
   output logic [2:0] lvdSel, // low-voltage threshold
   output logic low_voltage_detect_enable, // low-voltage enable
   output logic [1:0] avdSel, // analog threshold
   output logic avdEn, // analog enable
   output logic [1:0] ovdSel, // over-voltage threshold
   output logic ovdEn, // over-voltage enable
   output logic [1:0] uvdSel, // under-voltage threshold
   output logic uvdEn, // under-voltage enable
   output logic [2:0] regVsel, // regulator voltage select
   output logic lvdEventLine16, // event line 16 pulse
   output logic uvdIrq // under-voltage interrupt level
);
   typedef enum logic [1:0] {ST_IDLE, ST_PWR, ST_SYS} rsm_state_t;

   // ---------------- pin and comparator synchronisers
   logic [2:0] syncPor_q, syncCore_q, syncWake_q, syncBkp_q, syncPin_q, syncLvd_q, syncAvd_q;
   logic porLow_q, coreOk_q, wakeLvl_q, bkpLvl_q, pinLow_q, lvdLvl_q, avdLvl_q;
   logic wakePrev_q, corePrev_q, bkpPrev_q;
   logic [3:0] oeHist_q;

   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         syncPor_q <= 3'h0;
         syncCore_q <= 3'h0;
         syncWake_q <= 3'h0;
         syncBkp_q <= 3'h0;
         syncPin_q <= 3'h7;
         syncLvd_q <= 3'h0;
         syncAvd_q <= 3'h0;
      end else begin
         syncPor_q <= {syncPor_q[1:0], supplyOkN};
         syncCore_q <= {syncCore_q[1:0], coreSupplyOk};
         syncWake_q <= {syncWake_q[1:0], standbyWake};
         syncBkp_q <= {syncBkp_q[1:0], bkpPowerOn};
         syncPin_q <= {syncPin_q[1:0], extResetPinIn};
         syncLvd_q <= {syncLvd_q[1:0], lvdCmp};
         syncAvd_q <= {syncAvd_q[1:0], avdCmp};
      end
   end

   // level changes only when second and third stages agree
   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         porLow_q <= 1'b1;
         coreOk_q <= 1'b0;
         wakeLvl_q <= 1'b0;
         bkpLvl_q <= 1'b0;
         pinLow_q <= 1'b0;
         lvdLvl_q <= 1'b0;
         avdLvl_q <= 1'b0;
      end else begin
         if (syncPor_q[1] == syncPor_q[2]) porLow_q <= !syncPor_q[2];
         if (syncCore_q[1] == syncCore_q[2]) coreOk_q <= syncCore_q[2];
         if (syncWake_q[1] == syncWake_q[2]) wakeLvl_q <= syncWake_q[2];
         if (syncBkp_q[1] == syncBkp_q[2]) bkpLvl_q <= syncBkp_q[2];
         if (syncPin_q[1] == syncPin_q[2]) pinLow_q <= !syncPin_q[2];
         if (syncLvd_q[1] == syncLvd_q[2]) lvdLvl_q <= syncLvd_q[2];
         if (syncAvd_q[1] == syncAvd_q[2]) avdLvl_q <= syncAvd_q[2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         wakePrev_q <= 1'b0;
         corePrev_q <= 1'b0;
         bkpPrev_q <= 1'b0;
         oeHist_q <= 4'hf;
      end else begin
         wakePrev_q <= wakeLvl_q;
         corePrev_q <= coreOk_q;
         bkpPrev_q <= bkpLvl_q;
         oeHist_q <= {oeHist_q[2:0], extResetPinOe};
      end
   end

   logic wakeRise, coreRise, bkpRise, pinReq, sysReq, pwrReq;
   // own drive echoes through the synchroniser; ignore pin for that long
   assign pinReq = pinLow_q && !extResetPinOe && (oeHist_q == 4'h0);
   assign wakeRise = wakeLvl_q && !wakePrev_q;
   assign coreRise = coreOk_q && !corePrev_q;
   assign bkpRise = bkpLvl_q && !bkpPrev_q;
   assign pwrReq = porLow_q || wakeRise || coreRise; // [R6] [R8] [R9]
   assign sysReq = pinReq || swReset || wwdgReset || fwdgReset || lowPowerReset;

   // ---------------- reset sequencer
   rsm_state_t state_q;
   logic [15:0] rstCnt_q;
   localparam logic [15:0] RST_LEN = 16'(RST_CYCLES - 1);

   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         state_q <= ST_PWR;
         rstCnt_q <= 16'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               rstCnt_q <= 16'h0;
               if (pwrReq) state_q <= ST_PWR;
               else if (sysReq) state_q <= ST_SYS;
            end
            ST_PWR: begin
               if (porLow_q) rstCnt_q <= 16'h0; // [R8]
               else if (rstCnt_q == RST_LEN) state_q <= ST_IDLE;
               else rstCnt_q <= rstCnt_q + 16'h1;
            end
            ST_SYS: begin
               if (pwrReq) begin
                  state_q <= ST_PWR;
                  rstCnt_q <= 16'h0;
               end else if (rstCnt_q == RST_LEN) state_q <= ST_IDLE;
               else rstCnt_q <= rstCnt_q + 16'h1;
            end
            default: state_q <= ST_PWR;
         endcase
      end
   end

   rsm_state_t nextState;
   always_comb begin
      nextState = state_q;
      case (state_q)
         ST_IDLE: if (pwrReq) nextState = ST_PWR; else if (sysReq) nextState = ST_SYS;
         ST_PWR: if (!porLow_q && rstCnt_q == RST_LEN) nextState = ST_IDLE;
         ST_SYS: if (pwrReq) nextState = ST_PWR; else if (rstCnt_q == RST_LEN) nextState = ST_IDLE;
         default: nextState = ST_PWR;
      endcase
   end

   logic bkpRstBit_q;
   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         powerResetN <= 1'b0;
         systemResetN <= 1'b0;
         extResetPinOut <= 1'b0;
         extResetPinOe <= 1'b1;
         backupResetN <= 1'b1;
      end else begin
         powerResetN <= nextState != ST_PWR; // [R1]
         systemResetN <= nextState == ST_IDLE; // [R2]
         extResetPinOut <= 1'b0;
         extResetPinOe <= nextState != ST_IDLE; // [R3]
         backupResetN <= !(bkpRstBit_q || bkpRise); // [R7]
      end
   end

   // ---------------- bus slave
   logic dataPh_q, dataWr_q;
   logic [7:0] dataAddr_q;
   logic [5:0] flags_q;
   logic [2:0] lvdSelR, regVselR;
   logic [7:0] ovdFlt_q, uvdFlt_q;
   logic lvdFlag_q, avdFlag_q;
   logic [1:0] rawFlag, fltFlag;
   logic addrPh, wrEn;
   assign addrPh = hsel && htrans == rsm_pkg::HTRANS_NONSEQ && hready;
   assign wrEn = dataPh_q && dataWr_q;

   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         dataPh_q <= 1'b0;
         dataWr_q <= 1'b0;
         dataAddr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dataPh_q <= addrPh;
         dataWr_q <= addrPh && hwrite;
         if (addrPh) dataAddr_q <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic [31:0] rdMux;
   always_comb begin
      rdMux = rsm_pkg::ZERO32;
      case (haddr[7:0])
         rsm_pkg::OFF_RSTSRC: rdMux[rsm_pkg::FLAG_HI:rsm_pkg::FLAG_LO] = flags_q; // [R4]
         rsm_pkg::OFF_PWRCTL: begin
            rdMux[2:0] = lvdSel;
            rdMux[rsm_pkg::EN_BIT] = low_voltage_detect_enable;
         end
         rsm_pkg::OFF_PWRCTL0: rdMux[2:0] = regVsel;
         rsm_pkg::OFF_AVDCTL: begin
            rdMux[1:0] = avdSel;
            rdMux[rsm_pkg::EN_BIT] = avdEn;
         end
         rsm_pkg::OFF_OVDCTL: begin
            rdMux[1:0] = ovdSel;
            rdMux[rsm_pkg::EN_BIT] = ovdEn;
         end
         rsm_pkg::OFF_UVDCTL: begin
            rdMux[1:0] = uvdSel;
            rdMux[rsm_pkg::EN_BIT] = uvdEn;
         end
         rsm_pkg::OFF_OVDFLT: rdMux[7:0] = ovdFlt_q;
         rsm_pkg::OFF_UVDFLT: rdMux[7:0] = uvdFlt_q;
         rsm_pkg::OFF_STATUS: rdMux[5:0] = {fltFlag[1], rawFlag[1], fltFlag[0], rawFlag[0], avdFlag_q, lvdFlag_q};
         rsm_pkg::OFF_BKCTL: rdMux[rsm_pkg::BKRST_BIT] = bkpRstBit_q;
         default: rdMux = rsm_pkg::ZERO32;
      endcase
   end

   // read data sampled in the address phase, stands through data phase
   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) hrdata <= rsm_pkg::ZERO32;
      else if (addrPh && !hwrite) hrdata <= rdMux;
   end

   // control registers
   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         lvdSel <= rsm_pkg::LVD_SEL_RST;
         low_voltage_detect_enable <= 1'b0;
         regVsel <= rsm_pkg::VSEL_RST;
         avdSel <= rsm_pkg::SEL2_RST;
         avdEn <= 1'b0;
         ovdSel <= rsm_pkg::SEL2_RST;
         ovdEn <= 1'b0;
         uvdSel <= rsm_pkg::SEL2_RST;
         uvdEn <= 1'b0;
         ovdFlt_q <= rsm_pkg::FLT_RST;
         uvdFlt_q <= rsm_pkg::FLT_RST;
         bkpRstBit_q <= 1'b0;
      end else if (wrEn) begin
         case (dataAddr_q)
            rsm_pkg::OFF_PWRCTL: begin
               lvdSel <= hwdata[2:0]; // [R10]
               low_voltage_detect_enable <= hwdata[rsm_pkg::EN_BIT];
            end
            rsm_pkg::OFF_PWRCTL0: regVsel <= hwdata[2:0]; // [R22]
            rsm_pkg::OFF_AVDCTL: begin
               avdSel <= hwdata[1:0]; // [R13]
               avdEn <= hwdata[rsm_pkg::EN_BIT];
            end
            rsm_pkg::OFF_OVDCTL: begin
               ovdSel <= hwdata[1:0]; // [R15]
               ovdEn <= hwdata[rsm_pkg::EN_BIT]; // [R14]
            end
            rsm_pkg::OFF_UVDCTL: begin
               uvdSel <= hwdata[1:0]; // [R19]
               uvdEn <= hwdata[rsm_pkg::EN_BIT]; // [R18]
            end
            rsm_pkg::OFF_OVDFLT: ovdFlt_q <= hwdata[7:0]; // [R17]
            rsm_pkg::OFF_UVDFLT: uvdFlt_q <= hwdata[7:0]; // [R21]
            rsm_pkg::OFF_BKCTL: bkpRstBit_q <= hwdata[rsm_pkg::BKRST_BIT]; // [R7]
            default: ;
         endcase
      end
   end

   // ---------------- reset-source flags, set wins over clear
   logic flagClr;
   logic [5:0] flagSet;
   assign flagClr = wrEn && dataAddr_q == rsm_pkg::OFF_RSTSRC && hwdata[rsm_pkg::CLR_BIT];
   always_comb begin
      flagSet = 6'h00;
      if (state_q == ST_IDLE) begin
         flagSet[rsm_pkg::F_LP] = lowPowerReset;
         flagSet[rsm_pkg::F_WWDG] = wwdgReset;
         flagSet[rsm_pkg::F_FWDG] = fwdgReset;
         flagSet[rsm_pkg::F_SW] = swReset;
         flagSet[rsm_pkg::F_EP] = pinReq;
      end
      flagSet[rsm_pkg::F_POR] = porLow_q;
   end

   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) flags_q <= rsm_pkg::FLAGS_RST; // [R5]
      else flags_q <= (flagClr ? 6'h00 : flags_q) | flagSet; // [R4] [R5]
   end

   // ---------------- low-voltage and analog-supply detectors
   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) begin
         lvdFlag_q <= 1'b0;
         avdFlag_q <= 1'b0;
         lvdEventLine16 <= 1'b0;
      end else begin
         lvdFlag_q <= low_voltage_detect_enable && lvdLvl_q; // [R11]
         avdFlag_q <= avdEn && avdLvl_q; // [R13]
         lvdEventLine16 <= low_voltage_detect_enable && lvdLvl_q && !lvdFlag_q; // [R12]
      end
   end

   // ---------------- core over/under-voltage: two-flop sync and filter
   logic [1:0] coreCmp, coreEn;
   logic [7:0] fltLen [2];
   assign coreCmp = {uvdCmp, ovdCmp};
   assign coreEn = {uvdEn, ovdEn};
   assign fltLen[0] = ovdFlt_q;
   assign fltLen[1] = uvdFlt_q;
   localparam logic [9:0] UNIT_END = 10'(UNIT_CYCLES - 1);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_core
         logic s1_q, s2_q, raw_q, flt_q;
         logic [9:0] pre_q;
         logic [7:0] units_q;
         always_ff @(posedge core_clk) begin
            if (!external_reset_pin) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else begin
               s1_q <= coreCmp[gi];
               s2_q <= s1_q;
            end
         end
         always_ff @(posedge core_clk) begin
            if (!external_reset_pin) begin
               raw_q <= 1'b0;
               pre_q <= 10'h0;
               units_q <= 8'h0;
               flt_q <= 1'b0;
            end else begin
               raw_q <= coreEn[gi] && s2_q; // [R16] [R20]
               if (!raw_q) begin
                  pre_q <= 10'h0; // [R23]
                  units_q <= 8'h0;
                  flt_q <= 1'b0;
               end else if (units_q >= fltLen[gi]) begin
                  flt_q <= 1'b1; // [R17] [R21] [R23]
               end else if (pre_q == UNIT_END) begin
                  pre_q <= 10'h0;
                  units_q <= units_q + 8'h1;
               end else begin
                  pre_q <= pre_q + 10'h1;
               end
            end
         end
         assign rawFlag[gi] = raw_q;
         assign fltFlag[gi] = flt_q;
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!external_reset_pin) uvdIrq <= 1'b0;
      else uvdIrq <= fltFlag[1]; // [R21]
   end

   // ---------------- checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!external_reset_pin);

   sequence s_pwrStart;
      state_q == ST_IDLE && pwrReq;
   endsequence
   sequence s_pinLow;
      !extResetPinOut && extResetPinOe;
   endsequence

   property p_pinLowPwr;
      s_pwrStart |=> s_pinLow [*8];
   endproperty
   a_pinLowPwr: assert property (p_pinLowPwr) else $error("pin not low in reset"); // [R3]
   property p_pinFollows;
      !systemResetN |-> extResetPinOe;
   endproperty
   a_pinFollows: assert property (p_pinFollows) else $error("pin released early"); // [R3]
   property p_pwrImpliesSys;
      !powerResetN |-> !systemResetN;
   endproperty
   a_pwrImpliesSys: assert property (p_pwrImpliesSys) else $error("power without system"); // [R1]
   property p_porHold;
      porLow_q |=> !powerResetN;
   endproperty
   a_porHold: assert property (p_porHold) else $error("power reset not held"); // [R8]
   property p_swSys;
      state_q == ST_IDLE && !pwrReq && swReset |=> !systemResetN && powerResetN;
   endproperty
   a_swSys: assert property (p_swSys) else $error("sw reset scope wrong"); // [R2]
   property p_flagSticky;
      flags_q[rsm_pkg::F_SW] && !flagClr |=> flags_q[rsm_pkg::F_SW];
   endproperty
   a_flagSticky: assert property (p_flagSticky) else $error("flag lost"); // [R5]
   property p_setWins;
      flagClr && flagSet[rsm_pkg::F_SW] |=> flags_q[rsm_pkg::F_SW];
   endproperty
   a_setWins: assert property (p_setWins) else $error("set lost to clear"); // [R4]
   property p_lvdOff;
      !low_voltage_detect_enable |=> !lvdFlag_q && !lvdEventLine16;
   endproperty
   a_lvdOff: assert property (p_lvdOff) else $error("lvd active while off"); // [R11]
   property p_rawSync;
      ovdEn && $past(ovdEn) && $past(ovdEn, 2) && $past(ovdCmp, 3) |-> rawFlag[0];
   endproperty
   a_rawSync: assert property (p_rawSync) else $error("raw ovd late"); // [R16]
   property p_fltDrop;
      !rawFlag[1] |=> !fltFlag[1];
   endproperty
   a_fltDrop: assert property (p_fltDrop) else $error("filter not restarted"); // [R23]
   property p_fltWait;
      $rose(rawFlag[0]) && ovdFlt_q != 8'h00 |=> !fltFlag[0] [*8];
   endproperty
   a_fltWait: assert property (p_fltWait) else $error("filter too early"); // [R17]
   property p_bkp;
      bkpRstBit_q |=> !backupResetN;
   endproperty
   a_bkp: assert property (p_bkp) else $error("backup reset missing"); // [R7]
endmodule : rsm_reset_supply

// file: rsm_analog_model.sv
// Purpose: far-side model of supply comparators and the reset pin
// Assumes: pin has a pull-up; bench sets the analog state off the edge
// Notes: released pin reads high through the pull-up
`timescale 1ns/1ps
module rsm_analog_model (
   input wire logic [3:0] cmpReq, // lvd, avd, ovd, uvd wanted
   input wire logic [3:0] supReq, // backup on, wake, core up, supply low
   input wire logic pinPullLow, // external button on the pin
   input wire logic pinOut, // device pin value
   input wire logic pinOe, // device pin enable
   output logic supplyOkN, // low while main supply is low
   output logic coreSupplyOk, // core supply up
   output logic standbyWake, // standby return
   output logic bkpPowerOn, // backup power-on
   output logic extResetPinIn, // resolved pin level
   output logic lvdCmp, // low-voltage comparator
   output logic avdCmp, // analog comparator
   output logic ovdCmp, // over-voltage comparator
   output logic uvdCmp // under-voltage comparator
);
   assign {lvdCmp, avdCmp, ovdCmp, uvdCmp} = cmpReq;
   assign supplyOkN = ~supReq[0];
   assign coreSupplyOk = supReq[1];
   assign standbyWake = supReq[2];
   assign bkpPowerOn = supReq[3];
   // open drain: either party pulls low, else pull-up
   assign extResetPinIn = ((pinOe && !pinOut) || pinPullLow) ? 1'b0 : 1'b1;
endmodule : rsm_analog_model

// file: tb_rsm_reset_supply.sv
// Purpose: self-checking bench for the reset and supply monitor
// Assumes: zero-wait AHB-Lite slave, 10 MHz core_clk
// Notes: reset and filter counts shortened for run time
`timescale 1ns/1ps
module tb_rsm_reset_supply;
   localparam int RSTC = 20;
   localparam int UNIT = 4;
   localparam logic [31:0] FM = 32'hfc000000;
   logic core_clk = 1'b0;
   logic external_reset_pin = 1'b0;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [3:0] sysReq = 4'h0, cmpReq = 4'h0, supReq = 4'h2;
   logic pinPullLow = 1'b0;
   logic hreadyout, hresp, extResetPinIn, extResetPinOut, extResetPinOe;
   logic powerResetN, systemResetN, backupResetN, lvdEventLine16, uvdIrq;
   logic supplyOkN, coreSupplyOk, standbyWake, bkpPowerOn, lvdCmp, avdCmp, ovdCmp, uvdCmp;
   logic low_voltage_detect_enable, avdEn, ovdEn, uvdEn;
   logic [2:0] lvdSel, regVsel;
   logic [1:0] avdSel, ovdSel, uvdSel;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   rsm_reset_supply #(.RST_CYCLES(RSTC), .UNIT_CYCLES(UNIT)) dut (.core_clk, .external_reset_pin, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .supplyOkN, .coreSupplyOk, .standbyWake, .bkpPowerOn, .lowPowerReset(sysReq[3]),
      .wwdgReset(sysReq[2]), .fwdgReset(sysReq[1]), .swReset(sysReq[0]), .extResetPinIn,
      .extResetPinOut, .extResetPinOe, .powerResetN, .systemResetN, .backupResetN, .lvdCmp, .avdCmp,
      .ovdCmp, .uvdCmp, .lvdSel, .low_voltage_detect_enable, .avdSel, .avdEn, .ovdSel, .ovdEn, .uvdSel, .uvdEn, .regVsel,
      .lvdEventLine16, .uvdIrq);
   rsm_analog_model model (.cmpReq, .supReq, .pinPullLow, .pinOut(extResetPinOut), .pinOe(extResetPinOe),
      .supplyOkN, .coreSupplyOk, .standbyWake, .bkpPowerOn, .extResetPinIn, .lvdCmp, .avdCmp, .ovdCmp,
      .uvdCmp);
   always #50 core_clk = ~core_clk;
   task automatic end_sim;
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // called just after an edge; ends on the edge that takes the data
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= rsm_pkg::HTRANS_NONSEQ;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      compares++;
      if ((r & m) !== e || hresp !== 1'b0) begin
         fails++;
         $display("mismatch %s exp %h got %h", nm, e, r & m);
      end
   endtask : chk_rd
   task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk_out
   task automatic wait_rel;
      int n;
      n = 0;
      while (!(powerResetN === 1'b1 && systemResetN === 1'b1 && extResetPinOe === 1'b0) && n < 300) begin
         @(posedge core_clk);
         n++;
      end
      chk_out("release", 16'h1, {15'h0, n < 300});
   endtask : wait_rel
   // counts event pulses (s 0) or backup reset cycles (s 1)
   task automatic cnt(input int s, input logic [15:0] e);
      int n;
      n = 0;
      repeat (12) begin
         @(posedge core_clk);
         if ((s == 0) ? (lvdEventLine16 === 1'b1) : (backupResetN === 1'b0)) n++;
      end
      chk_out(s == 0 ? "lvdEvent" : "backupPulse", e, 16'(n));
   endtask : cnt
   initial begin
      logic [31:0] v [5];
      void'($urandom(72892));
      wt(6);
      external_reset_pin <= 1'b1;
      @(posedge core_clk);
      chk_out("powerResetN", 16'h0, powerResetN);
      chk_out("pinOe", 16'h1, extResetPinOe);
      wait_rel();
      chk_rd("flags", 8'h00, 32'h08000000, FM);
      wr(8'h00, 32'hfc000000);
      chk_rd("flags", 8'h00, 32'h08000000, FM);
      wr(8'h00, 32'h01000000);
      chk_rd("flags", 8'h00, 32'h0, FM);
      for (int k = 0; k < 5; k++) begin
         if (k == 0) pinPullLow <= 1'b1;
         else sysReq <= 4'h1 << (k - 1);
         @(posedge core_clk);
         sysReq <= 4'h0;
         wt(5);
         pinPullLow <= 1'b0;
         wt(3);
         chk_out("sysRst", 16'h3, {systemResetN, powerResetN, backupResetN});
         chk_out("pinDrive", 16'h2, {extResetPinOe, extResetPinOut});
         wait_rel();
         wt(8);
         v[0] = (k == 0) ? 32'h04000000 : 32'h1 << (27 + k);
         chk_rd("flags", 8'h00, v[0], FM);
         wr(8'h3c, 32'h01000000);
         chk_rd("flags", 8'h00, v[0], FM);
         wr(8'h00, 32'h01000000);
      end
      for (int j = 0; j < 3; j++) begin
         supReq <= 4'h2 ^ (4'h1 << j);
         wt(2);
         if (j == 1) supReq <= 4'h2;
         wt(6);
         chk_out("pwrRst", 16'h1, {powerResetN, systemResetN, backupResetN});
         chk_out("pinOe", 16'h1, extResetPinOe);
         supReq <= 4'h2;
         wait_rel();
         wt(4);
         chk_rd("flags", 8'h00, (j == 0) ? 32'h08000000 : 32'h0, FM);
         wr(8'h00, 32'h01000000);
      end
      for (int i = 0; i < 4; i++) begin
         foreach (v[n]) v[n] = $urandom;
         wr(rsm_pkg::OFF_PWRCTL, v[0]);
         wr(rsm_pkg::OFF_AVDCTL, v[1]);
         wr(rsm_pkg::OFF_OVDCTL, v[2]);
         wr(rsm_pkg::OFF_UVDCTL, v[3]);
         wr(rsm_pkg::OFF_PWRCTL0, v[4]);
         @(posedge core_clk);
         chk_out("fields", {v[0][2:0], v[0][4], v[1][1:0], v[1][4], v[2][1:0], v[2][4], v[3][1:0], v[3][4],
            v[4][2:0]}, {lvdSel, low_voltage_detect_enable, avdSel, avdEn, ovdSel, ovdEn, uvdSel, uvdEn, regVsel});
      end
      for (int d = 0; d < 2; d++) begin
         wr(8'h10 + 8'(4 * d), 32'h0);
         cmpReq <= 4'h2 >> d;
         wt(8);
         chk_rd("statusOff", rsm_pkg::OFF_STATUS, 32'h0, 32'hc << (2 * d));
         cmpReq <= 4'h0;
         wr(8'h10 + 8'(4 * d), 32'h10);
         wr(8'h18 + 8'(4 * d), 32'h2);
         cmpReq <= 4'h2 >> d;
         wt(6);
         cmpReq <= 4'h0;
         wt(6);
         chk_rd("spike", rsm_pkg::OFF_STATUS, 32'h0, 32'hc << (2 * d));
         cmpReq <= 4'h2 >> d;
         wt(6);
         chk_rd("raw", rsm_pkg::OFF_STATUS, 32'h4 << (2 * d), 32'hc << (2 * d));
         wt(20);
         chk_rd("filt", rsm_pkg::OFF_STATUS, 32'hc << (2 * d), 32'hc << (2 * d));
         chk_out("uvdIrq", 16'(d), uvdIrq);
         cmpReq <= 4'h0;
         wt(6);
         chk_rd("drop", rsm_pkg::OFF_STATUS, 32'h0, 32'hc << (2 * d));
      end
      wr(rsm_pkg::OFF_PWRCTL, 32'h0);
      cmpReq <= 4'h8;
      cnt(0, 16'h0);
      cmpReq <= 4'h0;
      wt(4);
      wr(rsm_pkg::OFF_PWRCTL, 32'h15);
      wr(rsm_pkg::OFF_AVDCTL, 32'h12);
      cmpReq <= 4'hc;
      cnt(0, 16'h1);
      chk_rd("status", rsm_pkg::OFF_STATUS, 32'h3, 32'h3);
      cmpReq <= 4'h8;
      wt(6);
      chk_rd("avd", rsm_pkg::OFF_STATUS, 32'h1, 32'h3);
      wr(rsm_pkg::OFF_BKCTL, 32'h1);
      wt(2);
      chk_out("bkRst", 16'h1, {backupResetN, powerResetN});
      wr(rsm_pkg::OFF_BKCTL, 32'h0);
      wt(2);
      chk_out("bkRst", 16'h1, backupResetN);
      supReq <= 4'ha;
      cnt(1, 16'h1);
      end_sim();
   end
endmodule : tb_rsm_reset_supply
